/* File: logic/lsmu_top.sv */
// Load/store move unit: byte loads and long-word loads and stores.
// Notes on behaviour
// [RULE1] Byte load indirect: read byte at source, sign-extend, write destination.
// [RULE2] Byte post-increment load: read, sign-extend, source plus one, write destination.
// [RULE3] Post-increment byte load with same register keeps the loaded byte.
// [RULE4] Indexed byte load address is index zero plus source.
// [RULE5] Global-base byte load adds zero-extended 8-bit displacement; result to index zero.
// [RULE6] Register-relative byte load adds 4-bit displacement to source; result to index zero.
// [RULE7] All effective addresses wrap modulo 32 bits.
// [RULE8] Long store indirect writes source to address in destination.
// [RULE9] Pre-decrement long store subtracts four, stores, writes address back.
// [RULE10] Indexed long store address is index zero plus destination.
// [RULE11] Global-base long store: displacement times four plus base; stores index zero.
// [RULE12] Register-relative long store: 4-bit displacement times four plus destination.
// [RULE13] Long load indirect writes the word unchanged to destination.
// [RULE14] Post-increment long load adds four to source, loads word into destination.
// [RULE15] Post-increment long load with same register keeps the loaded value.
// [RULE16] Stores may raise write address, miss, protection and first-write exceptions.
// [RULE17] Loads may raise read exceptions and then leave destination unwritten.
`timescale 1ns/1ns
`include "lsmu_params.svh"
module lsmu_top (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       issue_valid,
    input  wire logic [3:0]                 issue_op,
    input  wire logic [3:0]                 source_index,
    input  wire logic [3:0]                 destination_index,
    input  wire logic [7:0]                 disp,
    input  wire logic [31:0]                source_register,
    input  wire logic [31:0]                destination_register,
    input  wire logic [31:0]                index_register_zero,
    input  wire logic [31:0]                global_base,
    output logic                            issue_ready,
    output logic                            mem_req,
    output logic                            mem_write,
    output logic                            mem_long,
    output logic      [31:0]                mem_addr,
    output logic      [31:0]                mem_wdata,
    input  wire logic                       mem_ack,
    input  wire logic [31:0]                mem_rdata,
    input  wire logic [2:0]                 mem_fault,
    output logic                            wb_a_en,
    output logic      [3:0]                 wb_a_index,
    output logic      [31:0]                wb_a_data,
    output logic                            wb_b_en,
    output logic      [3:0]                 wb_b_index,
    output logic      [31:0]                wb_b_data,
    output logic                            done,
    output logic      [`LSMU_EXC_WIDTH-1:0] exception
);
    lsmu_pkg::lsmu_state_e state_reg;
    lsmu_pkg::lsmu_op_e    op_reg;
    logic [3:0]            src_idx_reg;
    logic [3:0]            dst_idx_reg;
    logic [31:0]           src_val_reg;
    logic [31:0]           dst_val_reg;
    logic [31:0]           addr_next;
    logic [31:0]           load_value;
    logic                  is_store;
    logic                  is_long;
    logic                  fault_any;
    logic [`LSMU_EXC_WIDTH-1:0] exc_next;

    function automatic logic op_is_store(input lsmu_pkg::lsmu_op_e o);
        op_is_store = (o == lsmu_pkg::LSMU_OP_STL_IND)  || (o == lsmu_pkg::LSMU_OP_STL_PRE) ||
                      (o == lsmu_pkg::LSMU_OP_STL_IDX)  || (o == lsmu_pkg::LSMU_OP_STL_GBR) ||
                      (o == lsmu_pkg::LSMU_OP_STL_DISP);
    endfunction

    function automatic logic op_is_long(input lsmu_pkg::lsmu_op_e o);
        op_is_long = op_is_store(o) || (o == lsmu_pkg::LSMU_OP_LDL_IND) ||
                     (o == lsmu_pkg::LSMU_OP_LDL_POST);
    endfunction

    // ----------------------------------------------------------------
    // Address generation
    // ----------------------------------------------------------------
    lsmu_agen u_agen (
        .op                   (issue_op),
        .source_register      (source_register),
        .destination_register (destination_register),
        .index_register_zero  (index_register_zero),
        .global_base          (global_base),
        .disp                 (disp),
        .address              (addr_next)
    );

    assign is_store  = op_is_store(op_reg);
    assign is_long   = op_is_long(op_reg);
    assign fault_any = |mem_fault;
    // Byte loads are sign-extended, long loads pass unchanged.
    assign load_value = is_long ? mem_rdata // [RULE1] [RULE13]
                                : {{24{mem_rdata[7]}}, mem_rdata[7:0]};

    // Fault code 1 is address error, 2 is translation miss, 3 protection, 4 first write.
    always_comb begin
        exc_next = '0;
        if (!is_store) begin
            exc_next[`LSMU_EXC_RADDR] = (mem_fault == 3'h1); // [RULE17]
            exc_next[`LSMU_EXC_RMISS] = (mem_fault == 3'h2); // [RULE17]
            exc_next[`LSMU_EXC_RPROT] = (mem_fault == 3'h3); // [RULE17]
        end else begin
            exc_next[`LSMU_EXC_WADDR]  = (mem_fault == 3'h1); // [RULE16]
            exc_next[`LSMU_EXC_WMISS]  = (mem_fault == 3'h2); // [RULE16]
            exc_next[`LSMU_EXC_WPROT]  = (mem_fault == 3'h3); // [RULE16]
            exc_next[`LSMU_EXC_FIRSTW] = (mem_fault == 3'h4); // [RULE16]
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= lsmu_pkg::LSMU_ST_IDLE;
        end else begin
            unique case (state_reg)
                lsmu_pkg::LSMU_ST_IDLE: begin
                    if (issue_valid) begin
                        state_reg <= lsmu_pkg::LSMU_ST_MEM;
                    end
                end
                lsmu_pkg::LSMU_ST_MEM: begin
                    if (mem_ack) begin
                        state_reg <= lsmu_pkg::LSMU_ST_DONE;
                    end
                end
                lsmu_pkg::LSMU_ST_DONE: state_reg <= lsmu_pkg::LSMU_ST_IDLE;
                default:                state_reg <= lsmu_pkg::LSMU_ST_IDLE;
            endcase
        end
    end

    // Operands are captured at issue so the register file may move on.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_reg      <= lsmu_pkg::LSMU_OP_LDB_IND;
            src_idx_reg <= 4'h0;
            dst_idx_reg <= 4'h0;
            src_val_reg <= 32'h0000_0000;
            dst_val_reg <= 32'h0000_0000;
        end else if (state_reg == lsmu_pkg::LSMU_ST_IDLE && issue_valid) begin
            op_reg      <= lsmu_pkg::lsmu_op_e'(issue_op);
            src_idx_reg <= source_index;
            dst_idx_reg <= destination_index;
            src_val_reg <= source_register;
            dst_val_reg <= destination_register;
        end
    end

    // ----------------------------------------------------------------
    // Memory request
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            mem_long  <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else if (state_reg == lsmu_pkg::LSMU_ST_IDLE && issue_valid) begin
            mem_req   <= 1'b1;
            mem_write <= op_is_store(lsmu_pkg::lsmu_op_e'(issue_op));
            mem_long  <= op_is_long(lsmu_pkg::lsmu_op_e'(issue_op));
            mem_addr  <= addr_next;
            // Global-base store sends index zero; all other stores send the source.
            if (lsmu_pkg::lsmu_op_e'(issue_op) == lsmu_pkg::LSMU_OP_STL_GBR) begin
                mem_wdata <= index_register_zero; // [RULE11]
            end else begin
                mem_wdata <= source_register; // [RULE8] [RULE10] [RULE12]
            end
        end else if (state_reg == lsmu_pkg::LSMU_ST_MEM && mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Write-back and completion
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_a_en    <= 1'b0;
            wb_a_index <= 4'h0;
            wb_a_data  <= 32'h0000_0000;
            wb_b_en    <= 1'b0;
            wb_b_index <= 4'h0;
            wb_b_data  <= 32'h0000_0000;
            done       <= 1'b0;
            exception  <= '0;
        end else begin
            wb_a_en   <= 1'b0;
            wb_b_en   <= 1'b0;
            done      <= 1'b0;
            exception <= '0;
            if (state_reg == lsmu_pkg::LSMU_ST_MEM && mem_ack) begin
                done      <= 1'b1;
                exception <= exc_next;
                // A faulting access writes no register at all.
                if (!fault_any) begin // [RULE16] [RULE17]
                    unique case (op_reg)
                        lsmu_pkg::LSMU_OP_LDB_IND, lsmu_pkg::LSMU_OP_LDB_IDX,
                        lsmu_pkg::LSMU_OP_LDL_IND: begin
                            wb_a_en    <= 1'b1; // [RULE1] [RULE4] [RULE13]
                            wb_a_index <= dst_idx_reg;
                            wb_a_data  <= load_value;
                        end
                        lsmu_pkg::LSMU_OP_LDB_GBR, lsmu_pkg::LSMU_OP_LDB_DISP: begin
                            wb_a_en    <= 1'b1; // [RULE5] [RULE6]
                            wb_a_index <= 4'h0;
                            wb_a_data  <= load_value;
                        end
                        lsmu_pkg::LSMU_OP_LDB_POST, lsmu_pkg::LSMU_OP_LDL_POST: begin
                            wb_a_en    <= 1'b1; // [RULE2] [RULE14]
                            wb_a_index <= dst_idx_reg;
                            wb_a_data  <= load_value;
                            // Same register: the increment is dropped.
                            wb_b_en    <= (src_idx_reg != dst_idx_reg); // [RULE3] [RULE15]
                            wb_b_index <= src_idx_reg;
                            wb_b_data  <= src_val_reg // [RULE2] [RULE14]
                                          + (is_long ? `LSMU_LONG_STEP : `LSMU_BYTE_STEP);
                        end
                        lsmu_pkg::LSMU_OP_STL_PRE: begin
                            wb_b_en    <= 1'b1; // [RULE9]
                            wb_b_index <= dst_idx_reg;
                            wb_b_data  <= mem_addr;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            issue_ready <= 1'b0;
        end else begin
            issue_ready <= (state_reg == lsmu_pkg::LSMU_ST_DONE) ||
                           (state_reg == lsmu_pkg::LSMU_ST_IDLE && !issue_valid);
        end
    end
endmodule

/* File: logic/lsmu_params.svh */
// Constants for the load/store move unit.
`ifndef LSMU_PARAMS_SVH
`define LSMU_PARAMS_SVH
`define LSMU_BYTE_STEP      32'h0000_0001
`define LSMU_LONG_STEP      32'h0000_0004
`define LSMU_LONG_SHIFT     2
`define LSMU_EXC_RADDR      0
`define LSMU_EXC_RMISS      1
`define LSMU_EXC_RPROT      2
`define LSMU_EXC_WADDR      3
`define LSMU_EXC_WMISS      4
`define LSMU_EXC_WPROT      5
`define LSMU_EXC_FIRSTW     6
`define LSMU_EXC_WIDTH      7
`endif

/* File: logic/lsmu_pkg.sv */
// Types for the load/store move unit.
package lsmu_pkg;
    typedef enum logic [3:0] {
        LSMU_OP_LDB_IND  = 4'h0,
        LSMU_OP_LDB_POST = 4'h1,
        LSMU_OP_LDB_IDX  = 4'h2,
        LSMU_OP_LDB_GBR  = 4'h3,
        LSMU_OP_LDB_DISP = 4'h4,
        LSMU_OP_STL_IND  = 4'h5,
        LSMU_OP_STL_PRE  = 4'h6,
        LSMU_OP_STL_IDX  = 4'h7,
        LSMU_OP_STL_GBR  = 4'h8,
        LSMU_OP_STL_DISP = 4'h9,
        LSMU_OP_LDL_IND  = 4'hA,
        LSMU_OP_LDL_POST = 4'hB
    } lsmu_op_e;
    typedef enum logic [1:0] {
        LSMU_ST_IDLE = 2'b00,
        LSMU_ST_MEM  = 2'b01,
        LSMU_ST_DONE = 2'b11
    } lsmu_state_e;
endpackage

/* File: logic/lsmu_agen.sv */
// Effective address generator for the load/store move unit.
`timescale 1ns/1ns
`include "lsmu_params.svh"
module lsmu_agen (
    input  wire logic [3:0]  op,
    input  wire logic [31:0] source_register,
    input  wire logic [31:0] destination_register,
    input  wire logic [31:0] index_register_zero,
    input  wire logic [31:0] global_base,
    input  wire logic [7:0]  disp,
    output logic      [31:0] address
);
    logic [31:0] disp8;
    logic [31:0] disp4;
    assign disp8 = {24'h00_0000, disp};
    assign disp4 = {28'h000_0000, disp[3:0]};

    // Sums keep only 32 bits, so addresses wrap around the address space.
    always_comb begin
        unique case (lsmu_pkg::lsmu_op_e'(op))
            lsmu_pkg::LSMU_OP_LDB_IND:  address = source_register; // [RULE1]
            lsmu_pkg::LSMU_OP_LDB_POST: address = source_register; // [RULE2]
            lsmu_pkg::LSMU_OP_LDB_IDX:
                address = index_register_zero + source_register; // [RULE4] [RULE7]
            lsmu_pkg::LSMU_OP_LDB_GBR:  address = global_base + disp8; // [RULE5] [RULE7]
            lsmu_pkg::LSMU_OP_LDB_DISP: address = source_register + disp4; // [RULE6] [RULE7]
            lsmu_pkg::LSMU_OP_STL_IND:  address = destination_register; // [RULE8]
            lsmu_pkg::LSMU_OP_STL_PRE:
                address = destination_register - `LSMU_LONG_STEP; // [RULE9] [RULE7]
            lsmu_pkg::LSMU_OP_STL_IDX:
                address = index_register_zero + destination_register; // [RULE10] [RULE7]
            lsmu_pkg::LSMU_OP_STL_GBR:
                address = global_base + (disp8 << `LSMU_LONG_SHIFT); // [RULE11] [RULE7]
            lsmu_pkg::LSMU_OP_STL_DISP:
                address = destination_register + (disp4 << `LSMU_LONG_SHIFT); // [RULE12] [RULE7]
            lsmu_pkg::LSMU_OP_LDL_IND:  address = source_register; // [RULE13]
            lsmu_pkg::LSMU_OP_LDL_POST: address = source_register; // [RULE14]
            default:                    address = 32'h0000_0000;
        endcase
    end
endmodule

/* File: testbench/lsmu_mem_model.sv */
// Memory access path model that answers the unit's requests.
`timescale 1ns/1ns
module lsmu_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        mem_req,
    input  wire logic [3:0]  cfg_delay,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic [2:0]  cfg_fault,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic [2:0]       mem_fault
);
    logic [3:0] wait_reg;
    // Off the answer cycle the lines show the inverse, so stale data is never taken as valid.
    assign mem_rdata = mem_ack ? cfg_rdata : ~cfg_rdata;
    assign mem_fault = mem_ack ? cfg_fault : ~cfg_fault;
    always_ff @(posedge clk_sys) begin
        if (rst || mem_ack || !mem_req) begin
            mem_ack  <= 1'b0;
            wait_reg <= 4'h0;
        end else if (wait_reg >= cfg_delay) begin
            mem_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

/* File: testbench/lsmu_chk.sv */
// Port checker for the load/store move unit.
`timescale 1ns/1ns
`include "lsmu_params.svh"
module lsmu_chk (
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire logic                       mem_req,
    input wire logic                       mem_write,
    input wire logic                       mem_long,
    input wire logic [31:0]                mem_addr,
    input wire logic [31:0]                mem_wdata,
    input wire logic                       mem_ack,
    input wire logic [31:0]                mem_rdata,
    input wire logic [2:0]                 mem_fault,
    input wire logic                       wb_a_en,
    input wire logic [31:0]                wb_a_data,
    input wire logic                       wb_b_en,
    input wire logic [31:0]                wb_b_data,
    input wire logic                       done,
    input wire logic                       issue_ready,
    input wire logic [`LSMU_EXC_WIDTH-1:0] exception
);
    logic        acc;
    logic        ld;
    logic [31:0] rd_q;
    logic [31:0] ad_q;
    logic        lg_q;
    assign acc = mem_req && mem_ack;
    assign ld  = acc && !mem_write && mem_fault == 3'h0;
    always_ff @(posedge clk_sys) begin
        rd_q <= mem_rdata;
        ad_q <= mem_addr;
        lg_q <= mem_long;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_done_after_ack: assert property (acc |=> done && !mem_req)
        else $error("done did not follow the memory answer");
    a_byte_sext: assert property (ld && !mem_long
        |=> wb_a_en && wb_a_data == {{24{rd_q[7]}}, rd_q[7:0]})
        else $error("byte load not sign-extended into write-back");
    a_long_whole: assert property (ld && mem_long |=> wb_a_en && wb_a_data == rd_q)
        else $error("long load data altered");
    a_load_fault_quiet: assert property (acc && !mem_write && mem_fault != 3'h0
        |=> !wb_a_en && !wb_b_en && exception == (7'h01 << ($past(mem_fault) - 3'h1)))
        else $error("faulting load wrote a register or flagged wrong exception");
    a_store_fault_flag: assert property (acc && mem_write && mem_fault != 3'h0
        |=> !wb_b_en && exception == (7'h08 << ($past(mem_fault) - 3'h1)))
        else $error("faulting store flagged wrong exception");
    a_store_no_load: assert property (acc && mem_write |=> !wb_a_en)
        else $error("store wrote loaded data");
    a_post_step: assert property (ld
        |=> !wb_b_en || wb_b_data == ad_q + (lg_q ? 32'h4 : 32'h1))
        else $error("post-increment step wrong");
    a_predec_back: assert property (acc && mem_write |=> !wb_b_en || wb_b_data == ad_q)
        else $error("pre-decrement write-back differs from store address");
    a_req_stable: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
        else $error("request dropped or changed before answer");
    a_done_has_cause: assert property (done |-> $past(acc))
        else $error("done without a memory answer");
    a_ready_busy: assert property (mem_req |-> !issue_ready)
        else $error("ready shown while an access is outstanding");
endmodule
bind lsmu_top lsmu_chk u_chk (.clk_sys, .rst, .mem_req, .mem_write, .mem_long, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .mem_fault, .wb_a_en, .wb_a_data, .wb_b_en,
    .wb_b_data, .done, .issue_ready, .exception);

/* File: testbench/tb_load_store_move_unit.sv */
// Self-checking testbench for the load/store move unit.
`timescale 1ns/1ns
module tb_load_store_move_unit;
    logic        clk_sys, rst, issue_valid, issue_ready, mem_req, mem_write, mem_long, mem_ack;
    logic        wb_a_en, wb_b_en, done;
    logic [3:0]  issue_op, source_index, destination_index, wb_a_index, wb_b_index, cfg_delay;
    logic [7:0]  disp;
    logic [2:0]  mem_fault, cfg_fault;
    logic [6:0]  exception;
    logic [31:0] source_register, destination_register, index_register_zero, global_base;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, wb_a_data, wb_b_data, cfg_rdata, r, s;
    logic [31:0] seed = 32'h0000004A;
    int          checks = 0;
    int          bad_count = 0;
    int          k;
    lsmu_top u_dut (.clk_sys, .rst, .issue_valid, .issue_op, .source_index, .destination_index,
        .disp, .source_register, .destination_register, .index_register_zero, .global_base,
        .issue_ready, .mem_req, .mem_write, .mem_long, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata, .mem_fault, .wb_a_en, .wb_a_index, .wb_a_data, .wb_b_en, .wb_b_index,
        .wb_b_data, .done, .exception);
    lsmu_mem_model u_mem (.clk_sys, .rst, .mem_req, .cfg_delay, .cfg_rdata, .cfg_fault,
        .mem_ack, .mem_rdata, .mem_fault);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    function automatic logic [31:0] exp_addr(input logic [3:0] op, input logic [7:0] d,
        input logic [31:0] sv, input logic [31:0] dv, input logic [31:0] zv, input logic [31:0] gv);
        case (op)
            4'h2: exp_addr = zv + sv;
            4'h3: exp_addr = gv + {24'h0, d};
            4'h4: exp_addr = sv + {28'h0, d[3:0]};
            4'h5: exp_addr = dv;
            4'h6: exp_addr = dv - 32'h4;
            4'h7: exp_addr = zv + dv;
            4'h8: exp_addr = gv + {22'h0, d, 2'b00};
            4'h9: exp_addr = dv + {26'h0, d[3:0], 2'b00};
            default: exp_addr = sv;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issues one instruction, holding it while busy, and checks the whole transfer.
    task automatic run_op(input logic [3:0] op, input logic [3:0] m, input logic [3:0] n,
        input logic [7:0] d, input logic [31:0] sv, input logic [31:0] dv, input logic [31:0] zv,
        input logic [31:0] gv, input logic [31:0] rdat, input logic [2:0] flt,
        input logic [3:0] dly);
        logic        st, ae, bb;
        logic [3:0]  ai, bi;
        logic [6:0]  ex;
        logic [31:0] ld, bd;
        logic [1:0]  got;
        int          i;
        st  = op inside {[4'h5:4'h9]};
        ae  = !st && flt == 3'h0;
        bb  = flt == 3'h0 && (((op == 4'h1 || op == 4'hB) && m != n) || op == 4'h6);
        ld  = op <= 4'h4 ? {{24{rdat[7]}}, rdat[7:0]} : rdat;
        ai  = (op == 4'h3 || op == 4'h4) ? 4'h0 : n;
        bi  = op == 4'h6 ? n : m;
        bd  = op == 4'h6 ? dv - 32'h4 : sv + (op == 4'h1 ? 32'h1 : 32'h4);
        ex  = flt == 3'h0 ? 7'h00 : (st ? 7'h08 : 7'h01) << (flt - 3'h1);
        got = 2'b00;
        {issue_op, source_index, destination_index, disp} = {op, m, n, d};
        {source_register, destination_register, index_register_zero, global_base} = {sv, dv, zv, gv};
        {cfg_rdata, cfg_fault, cfg_delay, issue_valid} = {rdat, flt, dly, 1'b1};
        for (i = 0; i < 40 && got != 2'b11; i++) begin
            @(negedge clk_sys);
            // The operands are spoiled only once the unit has taken them.
            if (mem_req === 1'b1) begin
                {source_register, destination_register} = ~{sv, dv};
            end
            if (mem_ack === 1'b1) begin
                got[0] = 1'b1;
                chk(mem_addr, exp_addr(op, d, sv, dv, zv, gv));
                chk(32'({mem_write, mem_long}), 32'({st, op > 4'h4}));
                if (st) chk(mem_wdata, op == 4'h8 ? zv : sv);
            end
            got[1] = got[1] | (done === 1'b1);
        end
        chk(32'(got), 32'h3);
        if (got != 2'b11) tally_and_finish();
        chk(32'(exception), 32'(ex));
        chk(32'({wb_a_en, wb_b_en}), 32'({ae, bb}));
        if (ae) chk(32'(wb_a_index), 32'(ai));
        if (ae) chk(wb_a_data, ld);
        if (bb) chk(32'(wb_b_index), 32'(bi));
        if (bb) chk(wb_b_data, bd);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst, issue_valid, issue_op, source_index, destination_index, disp} = {2'b10, 20'h0};
        {source_register, destination_register, index_register_zero, global_base} = '0;
        {cfg_rdata, cfg_fault, cfg_delay} = '0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        run_op(4'h1, 4'h5, 4'h5, 8'h00, 32'h1000, 32'h0, 32'h0, 32'h0,
            32'h80, 3'h0, 4'h0);
        run_op(4'hB, 4'h7, 4'h7, 8'h00, 32'h2000, 32'h0, 32'h0, 32'h0,
            32'hDEADBEEF, 3'h0, 4'h3);
        run_op(4'h1, 4'h1, 4'h2, 8'h00, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0,
            32'h7F, 3'h0, 4'h0);
        run_op(4'hB, 4'h3, 4'h4, 8'h00, 32'hFFFFFFFE, 32'h0, 32'h0, 32'h0,
            32'h5, 3'h0, 4'h1);
        run_op(4'h2, 4'h1, 4'h2, 8'h00, 32'hFFFFFFFF, 32'h0, 32'h2, 32'h0,
            32'hFF, 3'h0, 4'h0);
        run_op(4'h6, 4'h1, 4'h2, 8'h00, 32'h1234, 32'h2, 32'h0, 32'h0,
            32'h0, 3'h0, 4'h0);
        run_op(4'h8, 4'h1, 4'h2, 8'hFF, 32'h0, 32'h0, 32'hA5, 32'hFFFFFFF0,
            32'h0, 3'h0, 4'h2);
        run_op(4'h9, 4'h1, 4'h2, 8'hFF, 32'h9, 32'hFFFFFFFC, 32'h0, 32'h0,
            32'h0, 3'h0, 4'h0);
        run_op(4'h0, 4'h3, 4'h6, 8'h00, 32'h100, 32'h0, 32'h0, 32'h0,
            32'h1FE, 3'h0, 4'h0);
        run_op(4'h5, 4'h3, 4'h6, 8'h00, 32'hCAFE0001, 32'h300, 32'h0, 32'h0,
            32'h0, 3'h0, 4'h1);
        run_op(4'h7, 4'h3, 4'h6, 8'h00, 32'h11, 32'hFFFFFFF0, 32'h20, 32'h0,
            32'h0, 3'h0, 4'h0);
        run_op(4'hA, 4'h3, 4'h6, 8'h00, 32'h400, 32'h0, 32'h0, 32'h0,
            32'h80000001, 3'h0, 4'h0);
        run_op(4'h3, 4'h3, 4'h6, 8'hFF, 32'h0, 32'h0, 32'h0, 32'hFFFFFF80,
            32'h81, 3'h0, 4'h0);
        run_op(4'h4, 4'h3, 4'h6, 8'hF7, 32'hFFFFFFFA, 32'h0, 32'h0, 32'h0,
            32'h42, 3'h0, 4'h0);
        for (k = 1; k < 5; k++) begin
            run_op(4'h6, 4'h1, 4'h2, 8'h00, 32'h55, 32'h40, 32'h0, 32'h0,
                32'h0, 3'(k), 4'h0);
            if (k < 4) run_op(4'hB, 4'h1, 4'h2, 8'h00, 32'h40, 32'h0, 32'h0, 32'h0,
                32'h1, 3'(k), 4'h1);
        end
        $display("test corners done");
        for (k = 0; k < 80; k++) begin
            r = rnd();
            s = rnd();
            run_op(4'(r % 12), r[7:4], r[11:8], r[19:12], s, ~s,
                rnd(), rnd(), rnd(),
                r[26:25] == 2'b00 ? 3'(1 + r[29:27] % ((r % 12) inside {[5:9]} ? 4 : 3)) : 3'h0,
                4'(r[22:20]));
        end
        $display("test random done");
        issue_valid = 1'b0;
        tally_and_finish();
    end
endmodule
